/* File: verilog/dmapc_channel.sv */
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module dmapc_channel (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      resetn,
   // Register port
   input  wire logic [7:0]                reg_addr,
   input  wire logic [31:0]               reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic [31:0]                    reg_rdata,
   // Source read bus
   output logic                           bus_rd_req,
   output logic [dmapc_pkg::SAW-1:0]      bus_rd_addr,
   output logic [1:0]                     bus_rd_region,
   input  wire logic                      bus_rd_gnt,
   input  wire logic [7:0]                bus_rd_data,
   // Destination write bus
   output logic                           bus_wr_req,
   output logic [dmapc_pkg::DAW-1:0]      bus_wr_addr,
   output logic [7:0]                     bus_wr_data,
   input  wire logic                      bus_wr_gnt
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic                       enable;
   logic                       transfer_go;
   logic [1:0]                 src_addr_mode;
   logic [1:0]                 dst_addr_mode;
   logic [1:0]                 src_mem_region;
   logic [dmapc_pkg::SAW-1:0]  src_start_addr;
   logic [dmapc_pkg::DAW-1:0]  dst_start_addr;
   logic [dmapc_pkg::CW-1:0]   src_size;
   logic [dmapc_pkg::CW-1:0]   dst_size;
   logic [dmapc_pkg::SAW-1:0]  src_pointer;
   logic [dmapc_pkg::DAW-1:0]  dst_pointer;
   logic [dmapc_pkg::CW-1:0]   src_count;
   logic [dmapc_pkg::CW-1:0]   dst_count;
   logic [7:0]                 holding_buffer;
   logic                       write_pending_flag;
   dmapc_pkg::dmapc_state_t    state;
   logic                       rd_mirror;
   logic                       wr_mirror;
   logic [dmapc_pkg::SAW-1:0]  next_src_pointer;
   logic [dmapc_pkg::DAW-1:0]  next_dst_pointer;
   logic [dmapc_pkg::CW-1:0]   next_src_count;
   logic [dmapc_pkg::CW-1:0]   next_dst_count;
   logic                       src_wrap;
   logic                       dst_wrap;
   logic                       sw_wr;
   logic [3:0]                 sw_idx;
   logic                       mir_wr;
   logic [31:0]                wval;
   logic [31:0]                mir_word;
   logic [7:0]                 rd_byte;
   logic                       rd_done;
   logic                       wr_done;
   logic                       msg_end;
   logic                       run;
   logic                       en_rise;
   logic [31:0]                mir_src;
   logic                       src_in_mirror;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Address inside the channel-only mirror window
   function automatic logic in_mirror(input logic [15:0] a);
      return a[15:dmapc_pkg::MIRROR_LSB] == dmapc_pkg::MIRROR_BASE[15:dmapc_pkg::MIRROR_LSB];
   endfunction

   // Word view of one register
   function automatic logic [31:0] reg_word(input logic [3:0] idx);
      logic [31:0] w;
      w = 32'h0;
      case (idx)
         dmapc_pkg::IDX_CTRL:   w = {24'h0, src_mem_region, dst_addr_mode, src_addr_mode,
                                     transfer_go, enable};
         dmapc_pkg::IDX_STATUS: w = {30'h0, state != dmapc_pkg::ST_IDLE, write_pending_flag};
         dmapc_pkg::IDX_SSA:    w = {10'h0, src_start_addr};
         dmapc_pkg::IDX_DSA:    w = {16'h0, dst_start_addr};
         dmapc_pkg::IDX_SSZ:    w = {20'h0, src_size};
         dmapc_pkg::IDX_DSZ:    w = {20'h0, dst_size};
         dmapc_pkg::IDX_SPTR:   w = {10'h0, src_pointer};
         dmapc_pkg::IDX_DPTR:   w = {16'h0, dst_pointer};
         dmapc_pkg::IDX_SCNT:   w = {20'h0, src_count};
         dmapc_pkg::IDX_DCNT:   w = {20'h0, dst_count};
         dmapc_pkg::IDX_BUF:    w = {24'h0, holding_buffer};
         default:               w = 32'h0;
      endcase
      return w;
   endfunction

   // Write hit on one register from software or a mirror write
   function automatic logic wr_hit(input logic [3:0] idx);
      return (sw_wr && sw_idx == idx) || (!sw_wr && mir_wr && dst_pointer[5:2] == idx);
   endfunction

   // ------------------------------------------------------------
   // Pointer and counter steppers
   // ------------------------------------------------------------
   dmapc_step #(.AW(dmapc_pkg::SAW), .CW(dmapc_pkg::CW)) u_src_step (
      .ptr        (src_pointer),
      .count      (src_count),
      .start      (src_start_addr),
      .size       (src_size),
      .mode       (src_addr_mode),
      .next_ptr   (next_src_pointer),
      .next_count (next_src_count),
      .wrap       (src_wrap)
   );

   dmapc_step #(.AW(dmapc_pkg::DAW), .CW(dmapc_pkg::CW)) u_dst_step (
      .ptr        (dst_pointer),
      .count      (dst_count),
      .start      (dst_start_addr),
      .size       (dst_size),
      .mode       (dst_addr_mode),
      .next_ptr   (next_dst_pointer),
      .next_count (next_dst_count),
      .wrap       (dst_wrap)
   );

   // ------------------------------------------------------------
   // Decode and transaction events
   // ------------------------------------------------------------
   always_comb begin
      sw_idx  = reg_addr[5:2];
      sw_wr   = reg_wr && reg_addr[7:6] == 2'h0 && reg_addr[1:0] == 2'h0;
      run     = enable && transfer_go;
      rd_done = state == dmapc_pkg::ST_READ && run &&
                (rd_mirror || (bus_rd_req && bus_rd_gnt));
      wr_done = state == dmapc_pkg::ST_WRITE && run &&
                (wr_mirror || (bus_wr_req && bus_wr_gnt));
      mir_wr  = wr_done && wr_mirror;
      msg_end = wr_done && (src_wrap || dst_wrap);
      // Mirror reads pick one byte of the addressed register
      src_in_mirror = src_mem_region == dmapc_pkg::REGION_RAM &&
                      src_pointer[21:16] == 6'h00 && in_mirror(src_pointer[15:0]);
      mir_src = reg_word(src_pointer[5:2]);
      rd_byte = rd_mirror ? mir_src[8*src_pointer[1:0] +: 8] : bus_rd_data;
      // Mirror writes merge one byte into the addressed register
      mir_word = reg_word(dst_pointer[5:2]);
      mir_word[8*dst_pointer[1:0] +: 8] = bus_wr_data;
      wval    = sw_wr ? reg_wdata : mir_word;
      en_rise = !enable && wr_hit(dmapc_pkg::IDX_CTRL) && wval[dmapc_pkg::CTRL_EN];
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         enable         <= 1'b0;
         src_addr_mode  <= dmapc_pkg::MODE_FIXED;
         dst_addr_mode  <= dmapc_pkg::MODE_FIXED;
         src_mem_region <= dmapc_pkg::REGION_RAM;
      end else if (wr_hit(dmapc_pkg::IDX_CTRL)) begin
         enable         <= wval[dmapc_pkg::CTRL_EN];
         src_addr_mode  <= wval[dmapc_pkg::CTRL_SRC_ADDR_MODE_LO +: 2];
         dst_addr_mode  <= wval[dmapc_pkg::CTRL_DST_ADDR_MODE_LO +: 2];
         src_mem_region <= wval[dmapc_pkg::CTRL_REGION_LO +: 2];
      end
   end

   // Go bit: a set in the same cycle as the message end wins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         transfer_go <= 1'b0;
      end else if (wr_hit(dmapc_pkg::IDX_CTRL)) begin
         transfer_go <= wval[dmapc_pkg::CTRL_GO] & wval[dmapc_pkg::CTRL_EN];
      end else if (msg_end || !enable) begin
         transfer_go <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Start addresses and sizes
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         src_start_addr <= dmapc_pkg::SADDR_RST;
         dst_start_addr <= dmapc_pkg::DADDR_RST;
         src_size       <= dmapc_pkg::SIZE_RST;
         dst_size       <= dmapc_pkg::SIZE_RST;
      end else begin
         if (wr_hit(dmapc_pkg::IDX_SSA)) src_start_addr <= wval[dmapc_pkg::SAW-1:0];
         if (wr_hit(dmapc_pkg::IDX_DSA)) dst_start_addr <= wval[dmapc_pkg::DAW-1:0];
         if (wr_hit(dmapc_pkg::IDX_SSZ)) src_size <= wval[dmapc_pkg::CW-1:0];
         if (wr_hit(dmapc_pkg::IDX_DSZ)) dst_size <= wval[dmapc_pkg::CW-1:0];
      end
   end

   // ------------------------------------------------------------
   // Pointers and counters
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         src_pointer <= dmapc_pkg::SADDR_RST;
         dst_pointer <= dmapc_pkg::DADDR_RST;
         src_count   <= dmapc_pkg::SIZE_RST;
         dst_count   <= dmapc_pkg::SIZE_RST;
      end else if (en_rise) begin
         src_pointer <= src_start_addr;
         dst_pointer <= dst_start_addr;
         src_count   <= src_size;
         dst_count   <= dst_size;
      end else if (wr_done) begin
         src_pointer <= next_src_pointer;
         dst_pointer <= next_dst_pointer;
         src_count   <= next_src_count;
         dst_count   <= next_dst_count;
      end
   end

   // ------------------------------------------------------------
   // Holding buffer and pending flag
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         holding_buffer     <= 8'h00;
         write_pending_flag <= 1'b0;
      end else begin
         if (rd_done) begin
            holding_buffer     <= rd_byte;
            write_pending_flag <= 1'b1;
         end else if (wr_done || !enable) begin
            write_pending_flag <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Transaction sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state         <= dmapc_pkg::ST_IDLE;
         rd_mirror     <= 1'b0;
         wr_mirror     <= 1'b0;
         bus_rd_req    <= 1'b0;
         bus_rd_addr   <= dmapc_pkg::SADDR_RST;
         bus_rd_region <= dmapc_pkg::REGION_RAM;
         bus_wr_req    <= 1'b0;
         bus_wr_addr   <= dmapc_pkg::DADDR_RST;
         bus_wr_data   <= 8'h00;
      end else begin
         case (state)
            dmapc_pkg::ST_IDLE: begin
               if (run && !en_rise) begin
                  state         <= dmapc_pkg::ST_READ;
                  rd_mirror     <= src_in_mirror;
                  bus_rd_req    <= !src_in_mirror;
                  bus_rd_addr   <= src_pointer;
                  bus_rd_region <= src_mem_region;
               end
            end
            dmapc_pkg::ST_READ: begin
               if (!run) begin
                  state      <= dmapc_pkg::ST_IDLE;
                  bus_rd_req <= 1'b0;
               end else if (rd_done) begin
                  state       <= dmapc_pkg::ST_WRITE;
                  bus_rd_req  <= 1'b0;
                  wr_mirror   <= in_mirror(dst_pointer);
                  bus_wr_req  <= !in_mirror(dst_pointer);
                  bus_wr_addr <= dst_pointer;
                  bus_wr_data <= rd_byte;
               end
            end
            dmapc_pkg::ST_WRITE: begin
               if (!run || wr_done) begin
                  state      <= dmapc_pkg::ST_IDLE;
                  bus_wr_req <= 1'b0;
               end
            end
            default: begin
               state      <= dmapc_pkg::ST_IDLE;
               bus_rd_req <= 1'b0;
               bus_wr_req <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Register read port, data one cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd && reg_addr[7:6] == 2'h0 && reg_addr[1:0] == 2'h0) begin
         reg_rdata <= reg_word(sw_idx);
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   enable_load_a: assert property (@(posedge clk) disable iff (!resetn)
      en_rise |=> src_pointer == $past(src_start_addr) && src_count == $past(src_size) &&
                  dst_pointer == $past(dst_start_addr) && dst_count == $past(dst_size))
      else $error("enable did not load pointers and counters");
   read_then_write_a: assert property (@(posedge clk) disable iff (!resetn)
      rd_done |=> state == dmapc_pkg::ST_WRITE && bus_wr_data == $past(rd_byte))
      else $error("read not followed by write step");
   pending_set_a: assert property (@(posedge clk) disable iff (!resetn)
      state == dmapc_pkg::ST_WRITE && enable |-> write_pending_flag)
      else $error("pending flag low while write waits");
   pending_clr_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_done && !rd_done |=> !write_pending_flag)
      else $error("pending flag not cleared after write");
   grant_wait_a: assert property (@(posedge clk) disable iff (!resetn)
      bus_rd_req && !bus_rd_gnt && !rd_mirror |=> !write_pending_flag || $past(write_pending_flag))
      else $error("read taken without grant");
   src_inc_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_done && !src_wrap && src_addr_mode == dmapc_pkg::MODE_INC
      |=> src_pointer == $past(src_pointer) + 22'h1)
      else $error("source pointer did not increment");
   dst_dec_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_done && !dst_wrap && dst_addr_mode == dmapc_pkg::MODE_DEC
      |=> dst_pointer == $past(dst_pointer) - 16'h1)
      else $error("destination pointer did not decrement");
   count_step_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_done && !src_wrap && !dst_wrap
      |=> src_count == $past(src_count) - 12'h1 && dst_count == $past(dst_count) - 12'h1)
      else $error("counters did not decrement together");
   count_reload_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_done && src_wrap
      |=> src_count == $past(src_size) && src_pointer == $past(src_start_addr))
      else $error("source counter not reloaded from size");
   go_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      msg_end && !wr_hit(dmapc_pkg::IDX_CTRL) |=> !transfer_go && state == dmapc_pkg::ST_IDLE)
      else $error("go not cleared at message end");

endmodule

/* File: include/dmapc_pkg.sv */
package dmapc_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int SAW = 22;   // Source address, covers flash space
   localparam int DAW = 16;   // Destination address, data space
   localparam int CW  = 12;   // Size and counter width

   // ------------------------------------------------------------
   // Register word indices (byte offset is index times four)
   // ------------------------------------------------------------
   localparam logic [3:0] IDX_CTRL   = 4'h0;
   localparam logic [3:0] IDX_STATUS = 4'h1;
   localparam logic [3:0] IDX_SSA    = 4'h2;
   localparam logic [3:0] IDX_DSA    = 4'h3;
   localparam logic [3:0] IDX_SSZ    = 4'h4;
   localparam logic [3:0] IDX_DSZ    = 4'h5;
   localparam logic [3:0] IDX_SPTR   = 4'h6;
   localparam logic [3:0] IDX_DPTR   = 4'h7;
   localparam logic [3:0] IDX_SCNT   = 4'h8;
   localparam logic [3:0] IDX_DCNT   = 4'h9;
   localparam logic [3:0] IDX_BUF    = 4'ha;

   // ------------------------------------------------------------
   // Control and status field positions
   // ------------------------------------------------------------
   localparam int CTRL_EN        = 0;
   localparam int CTRL_GO        = 1;
   localparam int CTRL_SRC_ADDR_MODE_LO  = 2;
   localparam int CTRL_DST_ADDR_MODE_LO  = 4;
   localparam int CTRL_REGION_LO = 6;
   localparam int STAT_PENDING   = 0;
   localparam int STAT_BUSY      = 1;

   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_FIXED    = 2'h0;
   localparam logic [1:0] MODE_INC      = 2'h1;
   localparam logic [1:0] MODE_DEC      = 2'h2;
   localparam logic [1:0] REGION_RAM    = 2'h0;
   localparam logic [1:0] REGION_FLASH  = 2'h1;
   localparam logic [1:0] REGION_EEPROM = 2'h2;

   // ------------------------------------------------------------
   // Mirror window and reset values
   // ------------------------------------------------------------
   localparam logic [15:0]  MIRROR_BASE = 16'h4100;
   localparam int           MIRROR_LSB  = 6;
   localparam logic [SAW-1:0] SADDR_RST = 22'h000000;
   localparam logic [DAW-1:0] DADDR_RST = 16'h0000;
   localparam logic [CW-1:0]  SIZE_RST  = 12'h001;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } dmapc_state_t;

endpackage

/* File: verilog/dmapc_step.sv */
`timescale 1ns/1ps
module dmapc_step #(
   parameter int AW = 16,
   parameter int CW = 12
) (
   // Current state
   input  wire logic [AW-1:0] ptr,
   input  wire logic [CW-1:0] count,
   // Reload values and mode
   input  wire logic [AW-1:0] start,
   input  wire logic [CW-1:0] size,
   input  wire logic [1:0]    mode,
   // Stepped values
   output logic [AW-1:0]      next_ptr,
   output logic [CW-1:0]      next_count,
   output logic               wrap
);

   // ------------------------------------------------------------
   // One transaction step of a pointer and its counter
   // ------------------------------------------------------------
   always_comb begin
      wrap       = (count == CW'(1));
      next_count = count - CW'(1);
      next_ptr   = ptr;
      if (wrap) begin
         next_count = size;
         next_ptr   = start;
      end else begin
         case (mode)
            dmapc_pkg::MODE_INC: next_ptr = ptr + AW'(1);
            dmapc_pkg::MODE_DEC: next_ptr = ptr - AW'(1);
            default:             next_ptr = ptr;
         endcase
      end
   end

endmodule

/* File: bench/dmapc_mem.sv */
`timescale 1ns/1ps
module dmapc_mem (
   // Clock and arbiter control
   input  wire logic        clk,
   input  wire logic [1:0]  stall,
   // Channel requests
   input  wire logic        rd_req,
   input  wire logic [21:0] rd_addr,
   input  wire logic [1:0]  rd_region,
   input  wire logic        wr_req,
   input  wire logic [15:0] wr_addr,
   input  wire logic [7:0]  wr_data,
   // Grants, read data and write log
   output logic             rd_gnt,
   output logic             wr_gnt,
   output logic [7:0]       rd_data,
   output logic [15:0]      last_addr,
   output logic [7:0]       last_data,
   output logic [1:0]       last_region,
   output logic [7:0]       nwr
);
   logic [7:0] junk = 8'h00;
   initial nwr = 8'h00;
   // Grant only when not stalled, junk outside the grant cycle
   assign rd_gnt = rd_req & ~stall[0];
   assign wr_gnt = wr_req & ~stall[1];
   assign rd_data = rd_gnt ? (rd_addr[7:0] ^ 8'h5a) : junk;
   // Log each completed write
   always @(posedge clk) begin
      junk <= ~rd_data;
      if (rd_gnt) last_region <= rd_region;
      if (wr_gnt) begin
         last_addr <= wr_addr;
         last_data <= wr_data;
         nwr <= nwr + 8'h01;
      end
   end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
   $display("mismatch %0t got %h want %h", $time, a, b); end end
module tb;
   logic        clk, resetn, reg_wr, reg_rd, rd_req, rd_gnt, wr_req, wr_gnt;
   logic [7:0]  reg_addr, rd_data, wr_data, ldata, nwr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [21:0] rd_addr;
   logic [15:0] wr_addr, laddr;
   logic [1:0]  rd_region, lreg, stall;
   int          fail_count, checked;
   dmapc_channel dmapc_channel_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .bus_rd_req(rd_req), .bus_rd_addr(rd_addr), .bus_rd_region(rd_region),
      .bus_rd_gnt(rd_gnt), .bus_rd_data(rd_data), .bus_wr_req(wr_req),
      .bus_wr_addr(wr_addr), .bus_wr_data(wr_data), .bus_wr_gnt(wr_gnt));
   dmapc_mem dmapc_mem_i (.clk(clk), .stall(stall), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_region(rd_region), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_gnt(rd_gnt), .wr_gnt(wr_gnt), .rd_data(rd_data), .last_addr(laddr),
      .last_data(ldata), .last_region(lreg), .nwr(nwr));
   // Register port cycles
   task wr(input logic [3:0] i, input logic [31:0] v);
      @(posedge clk) begin reg_addr <= {2'h0, i, 2'h0}; reg_wdata <= v; reg_wr <= 1'b1; end
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] i);
      @(posedge clk) begin reg_addr <= {2'h0, i, 2'h0}; reg_rd <= 1'b1; end
      @(posedge clk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Poll until the go bit drops
   task wait_done;
      d = 32'h2;
      for (int k = 0; k < 60 && d[1] !== 1'b0; k++) rd(dmapc_pkg::IDX_CTRL);
   endtask
   // Uneven sizes, increment and decrement, flash source
   task t_uneven;
      wr(dmapc_pkg::IDX_SSA, 32'h100);
      wr(dmapc_pkg::IDX_DSA, 32'h200);
      wr(dmapc_pkg::IDX_SSZ, 32'h2);
      wr(dmapc_pkg::IDX_DSZ, 32'h3);
      wr(dmapc_pkg::IDX_CTRL, 32'h67);
      wait_done;
      `CHK(d, 32'h65)
      `CHK({nwr, laddr, ldata, lreg}, {8'h02, 16'h1ff, 8'h5b, 2'h1})
      rd(dmapc_pkg::IDX_SCNT); `CHK(d, 32'h2)
      rd(dmapc_pkg::IDX_SPTR); `CHK(d, 32'h100)
      rd(dmapc_pkg::IDX_DCNT); `CHK(d, 32'h1)
      rd(dmapc_pkg::IDX_DPTR); `CHK(d, 32'h1fe)
      wr(dmapc_pkg::IDX_CTRL, 32'h67);
      wait_done;
      `CHK({nwr, laddr, ldata}, {8'h03, 16'h1fe, 8'h5a})
      rd(dmapc_pkg::IDX_SCNT); `CHK(d, 32'h1)
      rd(dmapc_pkg::IDX_SPTR); `CHK(d, 32'h101)
      rd(dmapc_pkg::IDX_DCNT); `CHK(d, 32'h3)
      rd(dmapc_pkg::IDX_DPTR); `CHK(d, 32'h200)
   endtask
   // Fixed and undefined modes with stalled writes
   task t_fixed;
      wr(dmapc_pkg::IDX_CTRL, 32'h0);
      wr(dmapc_pkg::IDX_SSA, 32'h30);
      wr(dmapc_pkg::IDX_DSA, 32'h40);
      wr(dmapc_pkg::IDX_SSZ, 32'h3);
      stall <= 2'h3;
      wr(dmapc_pkg::IDX_CTRL, 32'h33);
      rd(dmapc_pkg::IDX_STATUS); `CHK(d[0], 1'b0)
      rd(dmapc_pkg::IDX_SPTR); `CHK(d, 32'h30)
      rd(dmapc_pkg::IDX_DCNT); `CHK(d, 32'h3)
      stall <= 2'h2;
      rd(dmapc_pkg::IDX_STATUS); `CHK(d[0], 1'b1)
      `CHK(nwr, 8'h03)
      stall <= 2'h0;
      wait_done;
      rd(dmapc_pkg::IDX_STATUS); `CHK(d[0], 1'b0)
      `CHK({nwr, laddr, ldata, lreg}, {8'h06, 16'h40, 8'h6a, 2'h0})
   endtask
   // EEPROM source with decrement and increment, then a mirror-window copy
   task t_spaces;
      wr(dmapc_pkg::IDX_CTRL, 32'h0);
      wr(dmapc_pkg::IDX_SSA, 32'h10);
      wr(dmapc_pkg::IDX_DSA, 32'h80);
      wr(dmapc_pkg::IDX_SSZ, 32'h2);
      wr(dmapc_pkg::IDX_DSZ, 32'h3);
      wr(dmapc_pkg::IDX_CTRL, 32'h9b);
      wait_done;
      `CHK({nwr, laddr, ldata, lreg}, {8'h08, 16'h81, 8'h55, 2'h2})
      rd(dmapc_pkg::IDX_DPTR); `CHK(d, 32'h82)
      wr(dmapc_pkg::IDX_CTRL, 32'h0);
      wr(dmapc_pkg::IDX_SSA, 32'h4110);
      wr(dmapc_pkg::IDX_DSA, 32'h4114);
      wr(dmapc_pkg::IDX_SSZ, 32'h1);
      wr(dmapc_pkg::IDX_DSZ, 32'h205);
      wr(dmapc_pkg::IDX_CTRL, 32'h3);
      wait_done;
      rd(dmapc_pkg::IDX_DSZ); `CHK(d, 32'h201)
      rd(dmapc_pkg::IDX_BUF); `CHK(d, 32'h1)
      rd(dmapc_pkg::IDX_DCNT); `CHK(d, 32'h204)
      `CHK(nwr, 8'h08)
   endtask
   // Verdict
   task final_report;
      if (fail_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, stall} = '0;
      fail_count = 0;
      checked = 0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rd(dmapc_pkg::IDX_SCNT); `CHK(d, 32'h1)
      t_uneven;
      t_fixed;
      t_spaces;
      final_report;
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      final_report;
   end
endmodule
